// ==== hdl/tdp_pkg.sv ====
// Notes on behaviour
// - Height doubling makes half the rows fill display
// - Double-height characters become quadruple height when doubling
// - Enlarge shows rows 0-11, or 12-24 when selected
// - Last-row-only blanks text rows 0 to 23
// - Prompt row 24 from extension row 0
// - Link control bit 3 reverts to basic row 24
// - Polarity bit 0 positive, 1 negative active pulse
// - Horizontal timing restarts on every active (leading) line sync edge
// - Default window starts 17.2 us, lasts 40 us
// - Vertical restarts per field sync, 250 lines shown
// - Field sync early in line even/low, late odd/high
// - Parity decision consistent even at line boundaries
// - Force-low bit holds de-interlace output at zero
// - Auto mode forces output low while video shown
// - Parity invert swaps field interpretation, may delay line
// - Parity invert never changes de-interlace output
// - Offset select gives 17.2/16.2/15.2/14.2 us start
// - Vertical select picks first line per 625/525 table
// - Other field starts on the equivalent line
package tdp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_SYNC    = 8'h04;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h08;
    localparam logic [7:0] ADDR_POS     = 8'h0C;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;

    localparam int A_ROW_ONLY  = 0;
    localparam int A_PROMPT    = 1;
    localparam int A_FRM_DIS   = 2;
    localparam int A_FRM_AUTO  = 3;
    localparam int S_HPOL      = 0;
    localparam int S_VPOL      = 1;
    localparam int S_FLD_POL   = 2;
    localparam int B_DBL       = 0;
    localparam int B_LOWER     = 1;
    localparam int P_HOFS      = 0;
    localparam int P_VSEL      = 2;

    localparam logic [3:0] CTRL_A_RST = 4'h0;
    localparam logic [2:0] SYNC_RST   = 3'h0;
    localparam logic [1:0] CTRL_B_RST = 2'h0;
    localparam logic [4:0] POS_RST    = 5'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int HSTART0_NS    = 17200;
    localparam int HSTART1_NS    = 16200;
    localparam int HSTART2_NS    = 15200;
    localparam int HSTART3_NS    = 14200;
    localparam int HWIDTH_NS     = 40000;
    localparam int HSTART0_CYC   = (HSTART0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HSTART1_CYC   = (HSTART1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HSTART2_CYC   = (HSTART2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HSTART3_CYC   = (HSTART3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HWIDTH_CYC    = (HWIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int VDISP_LINES   = 250;
    localparam int LINES_625_MIN = 288;
    localparam int ROW_LINES     = 10;
    localparam int ROWS_UPPER    = 12;
    localparam int LAST_ROW      = 24;

    localparam int FIRST_625 [8] = '{42, 44, 46, 48, 34, 36, 38, 40};
    localparam int FIRST_525 [8] = '{28, 30, 32, 34, 20, 22, 24, 26};

endpackage

// ==== hdl/tdp_sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Conditioned sync events, index 0 line sync, index 1 field sync
interface tdp_sync_if;
    logic [1:0] pol;
    logic [1:0] act_edge;
    modport cond (input pol, output act_edge);
    modport user (output pol, input act_edge);
endinterface
`default_nettype wire

// ==== hdl/tdp_sync_in.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdp_sync_in
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Sync pins
    input  wire logic [1:0] sync_pin_i,
    // Conditioned events
    tdp_sync_if.cond        sb
);
    import tdp_pkg::*;

    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic [1:0] lvl_prev_r;
    logic [1:0] lvl;

    // ----------------------------------------------------------------
    // Two-stage synchroniser per pin
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= 2'h0;
            sync_r <= 2'h0;
        end
        else
        begin
            meta_r <= sync_pin_i;
            sync_r <= meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Polarity and leading edge
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            assign lvl[g]         = sync_r[g] ^ sb.pol[g];
            assign sb.act_edge[g] = lvl[g] & ~lvl_prev_r[g];
        end
    endgenerate

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            lvl_prev_r <= 2'h3;
        else
            lvl_prev_r <= lvl;
    end

    property p_edge_pol;
        @(posedge ref_clk_i) disable iff (rst_i)
        (sb.pol[0] ? $fell(sync_r[0]) : $rose(sync_r[0])) && $stable(sb.pol[0]) |-> sb.act_edge[0];
    endproperty
    a_edge_pol: assert property (p_edge_pol) else $error("active line sync edge not detected");

endmodule
`default_nettype wire

// ==== hdl/tdp_display_timing.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdp_display_timing
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Scan sync pins
    input  wire logic        hsync_i,
    input  wire logic        vsync_i,
    // Display context
    input  wire logic        video_on_i,
    input  wire logic        dh_attr_i,
    input  wire logic        link_bit3_i,
    // Display outputs
    output logic             display_en_o,
    output logic [4:0]       text_row_o,
    output logic             row_from_ext_o,
    output logic             row_blank_o,
    output logic [2:0]       height_scale_o,
    output logic             frame_o
);
    import tdp_pkg::*;

    // ----------------------------------------------------------------
    // Registers and sync conditioning
    // ----------------------------------------------------------------
    logic [3:0]  ctrl_a_r;
    logic [2:0]  sync_cfg_r;
    logic [1:0]  ctrl_b_r;
    logic [4:0]  pos_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [11:0] hcnt_r;
    logic [11:0] line_len_r;
    logic [9:0]  vline_r;
    logic        is_625_r;
    logic        parity_r;
    logic [4:0]  row_r;
    logic [4:0]  lir_r;
    logic        h_edge;
    logic        v_edge;
    logic        field_odd;
    logic [9:0]  v_start;
    logic [11:0] h_start;
    logic        h_act;
    logic        v_act;
    logic [5:0]  disp_row;
    logic        row_vis;
    logic [4:0]  row_len;

    tdp_sync_if sb ();

    assign sb.pol = {sync_cfg_r[S_VPOL], sync_cfg_r[S_HPOL]};
    assign h_edge = sb.act_edge[0];
    assign v_edge = sb.act_edge[1];

    tdp_sync_in u_sync
    (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .sync_pin_i ({vsync_i, hsync_i}),
        .sb         (sb)
    );

    // ----------------------------------------------------------------
    // Decoders
    // ----------------------------------------------------------------
    function automatic logic [11:0] hstart_of(input logic [1:0] sel);
        logic [11:0] r;
        unique case (sel)
            2'h0: r = 12'(HSTART0_CYC);
            2'h1: r = 12'(HSTART1_CYC);
            2'h2: r = 12'(HSTART2_CYC);
            2'h3: r = 12'(HSTART3_CYC);
        endcase
        return r;
    endfunction

    function automatic logic [9:0] first_of(input logic is625, input logic [2:0] sel);
        return is625 ? 10'(FIRST_625[sel]) : 10'(FIRST_525[sel]);
    endfunction

    // ----------------------------------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------------------------------
    wire apb_setup = psel_i & ~penable_i;
    wire apb_wr    = psel_i & penable_i & pwrite_i;

    assign pready_o  = 1'b1;
    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r & psel_i & penable_i;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_a_r   <= CTRL_A_RST;
            sync_cfg_r <= SYNC_RST;
            ctrl_b_r   <= CTRL_B_RST;
            pos_r      <= POS_RST;
        end
        else if (apb_wr)
        begin
            unique case (paddr_i)
                ADDR_CTRL_A: ctrl_a_r   <= pwdata_i[3:0];
                ADDR_SYNC:   sync_cfg_r <= pwdata_i[2:0];
                ADDR_CTRL_B: ctrl_b_r   <= pwdata_i[1:0];
                ADDR_POS:    pos_r      <= pwdata_i[4:0];
                default:     ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (apb_setup)
        begin
            pslverr_r <= 1'b0;
            unique case (paddr_i)
                ADDR_CTRL_A: prdata_r <= {28'h0, ctrl_a_r};
                ADDR_SYNC:   prdata_r <= {29'h0, sync_cfg_r};
                ADDR_CTRL_B: prdata_r <= {30'h0, ctrl_b_r};
                ADDR_POS:    prdata_r <= {27'h0, pos_r};
                ADDR_STATUS: prdata_r <= {14'h0, row_r, field_odd, parity_r, is_625_r, vline_r};
                default:
                begin
                    prdata_r  <= 32'h0000_0000;
                    pslverr_r <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Horizontal timing
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            hcnt_r <= 12'h000;
        else if (h_edge)
            hcnt_r <= 12'h000;
        else if (hcnt_r != 12'hFFF)
            hcnt_r <= hcnt_r + 12'h001;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            line_len_r <= 12'h000;
        else if (h_edge)
            line_len_r <= hcnt_r;
    end

    assign h_start = hstart_of(pos_r[P_HOFS +: 2]);
    assign h_act   = (hcnt_r >= h_start) && (hcnt_r < h_start + 12'(HWIDTH_CYC));

    // ----------------------------------------------------------------
    // Vertical timing and standard detection
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            vline_r <= 10'h000;
        else if (v_edge)
            vline_r <= 10'h000;
        else if (h_edge && vline_r != 10'h3FF)
            vline_r <= vline_r + 10'h001;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            is_625_r <= 1'b1;
        else if (v_edge)
            is_625_r <= (vline_r >= 10'(LINES_625_MIN));
    end

    // Edge on the half-line point counts as second half
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            parity_r <= 1'b0;
        else if (v_edge)
            parity_r <= (hcnt_r >= {1'b0, line_len_r[11:1]});
    end

    assign field_odd = parity_r ^ sync_cfg_r[S_FLD_POL];
    assign v_start   = first_of(is_625_r, pos_r[P_VSEL +: 3]) + {9'h000, field_odd};
    assign v_act     = (vline_r >= v_start) && (vline_r < v_start + 10'(VDISP_LINES));

    // ----------------------------------------------------------------
    // Text rows
    // ----------------------------------------------------------------
    assign row_len = ctrl_b_r[B_DBL] ? 5'(2 * ROW_LINES) : 5'(ROW_LINES);

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            row_r <= 5'h00;
            lir_r <= 5'h00;
        end
        else if (h_edge)
        begin
            if (vline_r + 10'h001 == v_start)
            begin
                row_r <= 5'h00;
                lir_r <= 5'h00;
            end
            else if (lir_r >= row_len - 5'h01)
            begin
                lir_r <= 5'h00;
                if (row_r != 5'h1F)
                    row_r <= row_r + 5'h01;
            end
            else
                lir_r <= lir_r + 5'h01;
        end
    end

    assign disp_row = {1'b0, row_r}
                    + ((ctrl_b_r[B_DBL] && ctrl_b_r[B_LOWER]) ? 6'(ROWS_UPPER) : 6'h00);
    assign row_vis  = (disp_row <= 6'(LAST_ROW))
                    && !(ctrl_b_r[B_DBL] && !ctrl_b_r[B_LOWER] && disp_row >= 6'(ROWS_UPPER));

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            display_en_o   <= 1'b0;
            text_row_o     <= 5'h00;
            row_from_ext_o <= 1'b0;
            row_blank_o    <= 1'b1;
            height_scale_o <= 3'h1;
        end
        else
        begin
            display_en_o   <= h_act && v_act && row_vis;
            row_blank_o    <= !row_vis || (ctrl_a_r[A_ROW_ONLY] && disp_row < 6'(LAST_ROW));
            if (ctrl_a_r[A_PROMPT] && disp_row == 6'(LAST_ROW) && !link_bit3_i)
            begin
                row_from_ext_o <= 1'b1;
                text_row_o     <= 5'h00;
            end
            else
            begin
                row_from_ext_o <= 1'b0;
                text_row_o     <= disp_row[4:0];
            end
            unique case ({ctrl_b_r[B_DBL], dh_attr_i})
                2'b00:   height_scale_o <= 3'h1;
                2'b01:   height_scale_o <= 3'h2;
                2'b10:   height_scale_o <= 3'h2;
                2'b11:   height_scale_o <= 3'h4;
            endcase
        end
    end

    // Field-parity invert deliberately not used here
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            frame_o <= 1'b0;
        else if (ctrl_a_r[A_FRM_DIS])
            frame_o <= 1'b0;
        else if (ctrl_a_r[A_FRM_AUTO] && video_on_i)
            frame_o <= 1'b0;
        else
            frame_o <= parity_r;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_frame_dis;
        @(posedge ref_clk_i) disable iff (rst_i)
        ctrl_a_r[A_FRM_DIS] |=> !frame_o;
    endproperty
    a_frame_dis: assert property (p_frame_dis) else $error("frame not held low when disabled");

    property p_frame_auto;
        @(posedge ref_clk_i) disable iff (rst_i)
        ctrl_a_r[A_FRM_AUTO] && video_on_i |=> !frame_o;
    endproperty
    a_frame_auto: assert property (p_frame_auto) else $error("frame active while video shown");

    property p_frame_odd;
        @(posedge ref_clk_i) disable iff (rst_i)
        v_edge && hcnt_r >= {1'b0, line_len_r[11:1]} ##1 (ctrl_a_r[1:0] == 2'h0 && !ctrl_a_r[A_FRM_DIS]
            && !ctrl_a_r[A_FRM_AUTO] && !v_edge) |=> frame_o;
    endproperty
    a_frame_odd: assert property (p_frame_odd) else $error("late field sync did not give high frame");

    property p_hresync;
        @(posedge ref_clk_i) disable iff (rst_i)
        h_edge |=> hcnt_r == 12'h000 ##1 hcnt_r == 12'h001;
    endproperty
    a_hresync: assert property (p_hresync) else $error("line counter not restarted by line sync");

    property p_hstart;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(h_act) && $stable(pos_r) |-> hcnt_r == hstart_of(pos_r[P_HOFS +: 2]) && $past(hcnt_r) + 12'h001 == hcnt_r;
    endproperty
    a_hstart: assert property (p_hstart) else $error("window start at wrong clock count");

    property p_vresync;
        @(posedge ref_clk_i) disable iff (rst_i)
        v_edge |=> vline_r == 10'h000;
    endproperty
    a_vresync: assert property (p_vresync) else $error("field counter not restarted");

    property p_std;
        @(posedge ref_clk_i) disable iff (rst_i)
        v_edge && vline_r < 10'(LINES_625_MIN) |=> !is_625_r;
    endproperty
    a_std: assert property (p_std) else $error("short field not taken as 525-line");

    property p_row_only;
        @(posedge ref_clk_i) disable iff (rst_i)
        ctrl_a_r[A_ROW_ONLY] && disp_row < 6'(LAST_ROW) |=> row_blank_o;
    endproperty
    a_row_only: assert property (p_row_only) else $error("row shown in last-row-only mode");

    property p_prompt_fallback;
        @(posedge ref_clk_i) disable iff (rst_i)
        link_bit3_i |=> !row_from_ext_o;
    endproperty
    a_prompt_fallback: assert property (p_prompt_fallback) else $error("extension row used despite link bit");

    property p_quad;
        @(posedge ref_clk_i) disable iff (rst_i)
        ctrl_b_r[B_DBL] && dh_attr_i |=> height_scale_o == 3'h4;
    endproperty
    a_quad: assert property (p_quad) else $error("double height not made quadruple");

endmodule
`default_nettype wire

// ==== verif/tdp_scan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdp_scan_model
(
    // Clock
    input  wire logic        ref_clk_i,
    // Pulse shape
    input  wire logic [11:0] line_len_i,
    input  wire logic [11:0] fld_pos_i,
    input  wire logic        fld_req_i,
    input  wire logic        hpol_i,
    input  wire logic        vpol_i,
    // Sync pins
    output logic             hsync_o,
    output logic             vsync_o
);
    logic [11:0] hcnt_r = 12'h000;
    logic [7:0]  vcnt_r = 8'h00;
    logic        pend_r = 1'b0;
    logic        hit;

    // ----------------------------------------
    // Line and field pulses
    // ----------------------------------------
    assign hit = pend_r && (hcnt_r == fld_pos_i);

    always_ff @(posedge ref_clk_i)
    begin
        hcnt_r <= (hcnt_r >= line_len_i - 12'h001) ? 12'h000 : hcnt_r + 12'h001;
        if (fld_req_i)
            pend_r <= 1'b1;
        else if (hit)
            pend_r <= 1'b0;
        if (hit)
            vcnt_r <= 8'hC8;
        else if (vcnt_r != 8'h00)
            vcnt_r <= vcnt_r - 8'h01;
    end

    // Idle level is the inactive level of the chosen polarity
    assign hsync_o = (hcnt_r < 12'h064) ^ hpol_i;
    assign vsync_o = (vcnt_r != 8'h00) ^ vpol_i;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    import tdp_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hsync;
    logic        vsync;
    logic        video_on  = 1'b0;
    logic        dh_attr   = 1'b0;
    logic        link_bit3 = 1'b0;
    logic        display_en;
    logic [4:0]  text_row;
    logic        row_ext;
    logic        row_blank;
    logic [2:0]  hscale;
    logic        frame;
    logic [11:0] line_len  = 12'h320;
    logic [11:0] fld_pos   = 12'h064;
    logic        fld_req   = 1'b0;
    logic        hpol      = 1'b0;
    logic        vpol      = 1'b0;
    logic        hs_d      = 1'b0;
    logic [8:0]  snap;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [32:0] e_v;
    logic [32:0] m_v;
    logic [31:0] v;
    int          n_errors  = 0;
    int          n_compared = 0;
    int          cyc       = 0;
    int          hs_t      = 0;
    int          lines     = 0;
    int          d0;
    int          d;
    int          w;
    int          hst [4]   = '{HSTART0_CYC, HSTART1_CYC, HSTART2_CYC, HSTART3_CYC};
    logic [31:0] mk [4]    = '{32'hF, 32'h7, 32'h3, 32'h1F};
    logic [1:0]  mb [3]    = '{2'h1, 2'h1, 2'h3};
    logic        mdh [3]   = '{1'b0, 1'b1, 1'b0};
    logic [8:0]  mexp [3]  = '{{5'h00, 1'b0, 3'h2}, {5'h00, 1'b0, 3'h4}, {5'h0C, 1'b0, 3'h2}};

    always #12.5 ref_clk_i = ~ref_clk_i;

    tdp_display_timing tdp_display_timing_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .hsync_i(hsync), .vsync_i(vsync), .video_on_i(video_on),
        .dh_attr_i(dh_attr), .link_bit3_i(link_bit3), .display_en_o(display_en), .text_row_o(text_row),
        .row_from_ext_o(row_ext), .row_blank_o(row_blank), .height_scale_o(hscale), .frame_o(frame));

    tdp_scan_model tdp_scan_model_inst (.ref_clk_i(ref_clk_i), .line_len_i(line_len), .fld_pos_i(fld_pos),
        .fld_req_i(fld_req), .hpol_i(hpol), .vpol_i(vpol), .hsync_o(hsync), .vsync_o(vsync));

    // ----------------------------------------
    // Observers
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        hs_d <= hsync ^ hpol;
        if ((hsync ^ hpol) && !hs_d)
        begin
            hs_t <= cyc;
            lines <= lines + 1;
        end
    end

    always @(posedge ref_clk_i)
    begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
        begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            `CHK({pslverr, prdata} & m_v, e_v)
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic apb(input logic wr_i, input logic [7:0] a, input logic [31:0] dat);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_i;
        paddr <= a;
        pwdata <= dat;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] ex, input logic [32:0] m);
        exp_q.push_back(ex);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_lines(input int n);
        int t;
        t = lines + n;
        while (lines < t)
            @(negedge ref_clk_i);
    endtask

    task automatic meas(output int dl, output int wd);
        int k;
        k = 0;
        while (display_en !== 1'b0 && k < 20000)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        while (display_en !== 1'b1 && k < 20000)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        dl = cyc - hs_t;
        snap = {text_row, row_blank, hscale};
        wd = 0;
        while (display_en === 1'b1 && wd < 5000)
        begin
            @(negedge ref_clk_i);
            wd++;
        end
    endtask

    task automatic field(input logic [11:0] p);
        fld_pos <= p;
        fld_req <= 1'b1;
        @(negedge ref_clk_i);
        fld_req <= 1'b0;
        wait_lines(2);
    endtask

    task automatic test_done;
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        v = $urandom(91);
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(negedge ref_clk_i);
        `CHK({pready, display_en, row_blank, hscale, frame}, 7'b1010010)
        for (int i = 0; i < 4; i++)
            rd(8'(4 * i), 33'h0, '1);
        rd(8'h14, {1'b1, 32'h0}, '1);
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            apb(1'b1, 8'(4 * i), v);
            rd(8'(4 * i), {1'b0, v & mk[i]}, '1);
            apb(1'b1, 8'(4 * i), 32'h0);
        end
        // Short field, then a field in 525-line mode
        apb(1'b1, ADDR_POS, 32'h10);
        wait_lines(2);
        field(12'h064);
        wait_lines(4);
        field(12'h064);
        wait_lines(16);
        line_len <= 12'h960;
        meas(d, w);
        rd(ADDR_STATUS, {1'b0, 32'(FIRST_525[4])}, {1'b0, 32'h7FF});
        meas(d0, w);
        `CHK(w, HWIDTH_CYC)
        `CHK(snap, {5'h00, 1'b0, 3'h1})
        for (int h = 1; h < 4; h++)
        begin
            apb(1'b1, ADDR_POS, 32'h10 | 32'(h));
            meas(d, w);
            `CHK(d0 - d, HSTART0_CYC - hst[h])
        end
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, ADDR_CTRL_B, 32'(mb[i]));
            dh_attr <= mdh[i];
            meas(d, w);
            `CHK(snap, mexp[i])
        end
        apb(1'b1, ADDR_CTRL_B, 32'h0);
        dh_attr <= 1'b0;
        apb(1'b1, ADDR_CTRL_A, 32'h1);
        wait_lines(1);
        repeat (800) @(negedge ref_clk_i);
        `CHK(row_blank, 1'b1)
        apb(1'b1, ADDR_CTRL_A, 32'h2);
        apb(1'b1, ADDR_POS, 32'h10);
        // Prompt row on very short lines, sync pins inverted
        line_len <= 12'h070;
        hpol <= 1'b1;
        vpol <= 1'b1;
        apb(1'b1, ADDR_SYNC, 32'h3);
        wait_lines(2);
        field(12'h010);
        wait_lines(262);
        repeat (20) @(negedge ref_clk_i);
        `CHK({row_ext, text_row}, 6'h20)
        @(posedge ref_clk_i);
        link_bit3 <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        `CHK({row_ext, text_row}, 6'h18)
        @(posedge ref_clk_i);
        link_bit3 <= 1'b0;
        line_len <= 12'h320;
        meas(d, w);
        `CHK(d, d0)
        apb(1'b1, ADDR_CTRL_A, 32'h0);
        // Field parity on short lines
        wait_lines(2);
        field(12'h064);
        `CHK(frame, 1'b0)
        field(12'h2BC);
        `CHK(frame, 1'b1)
        field(12'h186);
        `CHK(frame, 1'b0)
        field(12'h19A);
        `CHK(frame, 1'b1)
        apb(1'b1, ADDR_CTRL_A, 32'h4);
        repeat (3) @(negedge ref_clk_i);
        `CHK(frame, 1'b0)
        apb(1'b1, ADDR_CTRL_A, 32'h8);
        video_on <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        `CHK(frame, 1'b0)
        @(posedge ref_clk_i);
        video_on <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        `CHK(frame, 1'b1)
        apb(1'b1, ADDR_SYNC, 32'h7);
        field(12'h2BC);
        `CHK(frame, 1'b1)
        rd(ADDR_STATUS, {1'b0, 32'h800}, {1'b0, 32'h1800});
        test_done;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk_i);
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire
